// File: caption_pkg.sv
// Purpose: Shared constants for the line-21 caption inserter.
// Assumes: 32-bit AHB-Lite register access, 10 MHz ref_clk.
// Notes: Offsets are byte addresses (index times four).
package caption_pkg;
	localparam int unsigned REF_CLK_HZ = 10000000;
	localparam int unsigned CAP_LINE_ODD = 21;
	localparam int unsigned CAP_LINE_EVEN = 284;
	localparam logic [7:0] IDX_EVEN_A = 8'h91;
	localparam logic [7:0] IDX_EVEN_B = 8'h92;
	localparam logic [7:0] IDX_ODD_A = 8'h93;
	localparam logic [7:0] IDX_ODD_B = 8'h94;
	localparam logic [7:0] IDX_CTRL = 8'hA0;
	localparam logic [7:0] IDX_STATUS = 8'hA1;
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_ODD_DONE_BIT = 1;
	localparam int unsigned STAT_EVEN_DONE_BIT = 2;
	localparam logic [7:0] CAP_BYTE_RESET = 8'h00;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int unsigned RUNIN_CYCLES = 7;
	localparam int unsigned BLANK_BITS = 2;
	localparam int unsigned PAYLOAD_BITS = 16;
	// One caption bit is 32 times the line rate: about 503 kHz.
	localparam int unsigned BIT_RATE_HZ = 503497;
	localparam int unsigned BIT_CYCLES = REF_CLK_HZ / BIT_RATE_HZ;
	localparam int unsigned SINE_STEPS = 8;
	localparam logic [9:0] LEVEL_BLANK = 10'h0F0;
	localparam logic [9:0] LEVEL_HIGH = 10'h1F0;

	function automatic logic [11:0] byte_addr(input logic [7:0] idx);
		byte_addr = {2'b00, idx, 2'b00};
	endfunction : byte_addr

	function automatic logic [7:0] odd_parity(input logic [7:0] b);
		odd_parity = {~^b[6:0], b[6:0]};
	endfunction : odd_parity
endpackage : caption_pkg

// File: caption_if.sv
// Purpose: Carries bits from the framer into the shift buffer.
// Assumes: One clock domain.
// Notes: Valid and ready handshake.
`timescale 1ns/10ps
`default_nettype none
interface caption_if #(parameter int WIDTH = 1);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : caption_if
`default_nettype wire

// File: caption_fifo.sv
// Purpose: Parameterised FIFO between framer and waveform stage.
// Assumes: Synchronous active-low reset.
// Notes: Honest full and empty.
`timescale 1ns/10ps
`default_nettype none
module caption_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	caption_if.sink in_port,
	caption_if.source out_port
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin
			$error("DEPTH must be a power of two, at least 2");
		end
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty = (wr_q == rd_q);
	assign in_port.ready = ~full;
	assign out_port.valid = ~empty;
	assign out_port.data = mem[rd_q[AW-1:0]];
	always_ff @(posedge ref_clk) begin
		if (in_port.valid && !full) begin
			mem[wr_q[AW-1:0]] <= in_port.data;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_q <= '0;
		end else if (in_port.valid && !full) begin
			wr_q <= wr_q + 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_q <= '0;
		end else if (out_port.ready && !empty) begin
			rd_q <= rd_q + 1'b1;
		end
	end
endmodule : caption_fifo
`default_nettype wire

// File: caption_inserter.sv
// Purpose: Inserts caption bits on lines 21 and 284 of SD video.
// Assumes: line_num and field_even come from the SD timing generator.
// Notes: Bits travel through a 16-deep FIFO to the waveform stage.
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1 - Captions go out only on line 21 odd and line 284 even.
// R2 - Each line opens with a seven-cycle sine run-in locked to bit rate.
// R3 - Two blanking bit periods then a high start bit follow the run-in.
// R4 - Sixteen payload bits follow: two bytes, seven data bits plus odd parity.
// R5 - Odd-field bytes come from registers at 0x93 and 0x94.
// R6 - Even-field line 284 bytes come from registers at 0x91 and 0x92.
// R7 - With captions on, pixel input is ignored on both caption lines.
// R8 - Registers are single-buffered; data goes out on the very next caption line of its field.
// R9 - Host finishes writing at least one line before the caption line.
// R10 - Host writes zeros to both bytes when nothing is new.
// R11 - Host should reload both bytes every field on vertical sync.
// R12 - Host sends two-byte control codes on line 21.
// R13 - Host pads odd-length messages with one blank character.
// R14 - Register pair is captured at line start, shielded from later writes.
module caption_inserter (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hsel,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic line_start,
	input wire logic [9:0] line_num,
	input wire logic field_even,
	input wire logic active_video,
	input wire logic [9:0] pixel_in,
	output logic [9:0] video_out
);
	import caption_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_RUNIN = 3'b010,
		ST_DATA = 3'b011
	} wave_state_type;

	// ==========================================================
	// Bus slave
	logic [7:0] even_a_q;
	logic [7:0] even_b_q;
	logic [7:0] odd_a_q;
	logic [7:0] odd_b_q;
	logic enable_q;
	logic odd_done_q;
	logic even_done_q;
	logic wr_pend_q;
	logic [11:0] addr_q;
	logic busy;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			addr_q <= 12'h000;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans[1] && hwrite;
			addr_q <= haddr[11:0];
		end
	end

	// The byte registers feed the next caption line directly, with no second
	// buffer, so a write lands on the very next caption line of its field.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			even_a_q <= CAP_BYTE_RESET;
			even_b_q <= CAP_BYTE_RESET;
			odd_a_q <= CAP_BYTE_RESET;
			odd_b_q <= CAP_BYTE_RESET;
			enable_q <= CTRL_RESET[CTRL_ENABLE_BIT];
		end else if (wr_pend_q) begin // see R8
			if (addr_q == byte_addr(IDX_EVEN_A)) even_a_q <= hwdata[7:0];
			if (addr_q == byte_addr(IDX_EVEN_B)) even_b_q <= hwdata[7:0];
			if (addr_q == byte_addr(IDX_ODD_A)) odd_a_q <= hwdata[7:0];
			if (addr_q == byte_addr(IDX_ODD_B)) odd_b_q <= hwdata[7:0];
			if (addr_q == byte_addr(IDX_CTRL)) begin
				enable_q <= hwdata[CTRL_ENABLE_BIT];
			end
		end
	end

	function automatic logic [31:0] read_mux(input logic [11:0] a);
		read_mux = 32'h0000_0000;
		if (a == byte_addr(IDX_EVEN_A)) read_mux[7:0] = even_a_q;
		if (a == byte_addr(IDX_EVEN_B)) read_mux[7:0] = even_b_q;
		if (a == byte_addr(IDX_ODD_A)) read_mux[7:0] = odd_a_q;
		if (a == byte_addr(IDX_ODD_B)) read_mux[7:0] = odd_b_q;
		if (a == byte_addr(IDX_CTRL)) read_mux[CTRL_ENABLE_BIT] = enable_q;
		if (a == byte_addr(IDX_STATUS)) begin
			read_mux[STAT_BUSY_BIT] = busy;
			read_mux[STAT_ODD_DONE_BIT] = odd_done_q;
			read_mux[STAT_EVEN_DONE_BIT] = even_done_q;
		end
	endfunction : read_mux

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= read_mux(haddr[11:0]);
		end
	end

	// ==========================================================
	// Framer: loads 19 bit symbols per caption line into the FIFO
	caption_if #(.WIDTH(1)) to_fifo ();
	caption_if #(.WIDTH(1)) from_fifo ();

	logic is_cap_line;
	logic [18:0] frame_q;
	logic [4:0] push_cnt_q;
	logic cap_line_q;

	// Only the two caption lines, each in its own field, qualify.
	assign is_cap_line = enable_q && (field_even ? // see R1
		(line_num == 10'(CAP_LINE_EVEN)) : (line_num == 10'(CAP_LINE_ODD)));

	// The byte pair is latched at line start into the shift word, so a host
	// write during the line cannot tear the bits already on their way.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frame_q <= '0;
			push_cnt_q <= 5'd0;
			cap_line_q <= 1'b0;
		end else if (line_start) begin // see R14
			cap_line_q <= is_cap_line;
			push_cnt_q <= is_cap_line ? 5'd19 : 5'd0;
			// Two blanking bits, the start bit, then both parity bytes.
			// Byte A goes out first, least significant bit first.
			frame_q <= field_even ? // see R3, R4, R5, R6
				{odd_parity(even_b_q), odd_parity(even_a_q), 1'b1, 2'b00} :
				{odd_parity(odd_b_q), odd_parity(odd_a_q), 1'b1, 2'b00};
		end else if (to_fifo.valid && to_fifo.ready) begin
			frame_q <= {1'b0, frame_q[18:1]};
			push_cnt_q <= push_cnt_q - 5'd1;
		end
	end

	assign to_fifo.valid = (push_cnt_q != 5'd0);
	assign to_fifo.data = frame_q[0];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			odd_done_q <= 1'b0;
			even_done_q <= 1'b0;
		end else if (line_start && is_cap_line) begin
			odd_done_q <= ~field_even;
			even_done_q <= field_even;
		end
	end

	caption_fifo #(.WIDTH(1), .DEPTH(16)) u_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_port(to_fifo.sink),
		.out_port(from_fifo.source)
	);

	// ==========================================================
	// Waveform generator
	wave_state_type state_q;
	logic [7:0] bit_tick_q;
	logic [2:0] phase_q;
	logic [3:0] runin_q;
	logic [4:0] sym_q;
	logic tick;

	// The sub-tick compare, phase counter, run-in counter and frame word
	// are sized for the package values; refuse values they cannot carry.
	if (BIT_CYCLES / SINE_STEPS < 1) begin : g_bad_rate
		$error("Caption bit is shorter than one sine step.");
	end
	if (BIT_CYCLES / SINE_STEPS > 256) begin : g_bad_div
		$error("Sub-tick divider does not fit its counter.");
	end
	if (SINE_STEPS != 8) begin : g_bad_steps
		$error("The sine table has exactly eight steps.");
	end
	if (RUNIN_CYCLES < 1 || RUNIN_CYCLES > 15) begin : g_bad_runin
		$error("Run-in count does not fit its counter.");
	end
	if (BLANK_BITS + 1 + PAYLOAD_BITS != 19) begin : g_bad_frame
		$error("The frame word holds exactly nineteen symbols.");
	end

	function automatic logic [9:0] sine_level(input logic [2:0] ph);
		unique case (ph)
			3'd0: sine_level = LEVEL_BLANK;
			3'd1, 3'd3: sine_level = LEVEL_BLANK + 10'h05A;
			3'd2: sine_level = LEVEL_HIGH;
			3'd5, 3'd7: sine_level = LEVEL_BLANK - 10'h05A;
			default: sine_level = LEVEL_BLANK - 10'h080;
		endcase
	endfunction : sine_level

	assign tick = (bit_tick_q == 8'(BIT_CYCLES / SINE_STEPS - 1));
	assign busy = (state_q != ST_IDLE);
	assign from_fifo.ready = (state_q == ST_DATA) && tick &&
		(phase_q == 3'(SINE_STEPS - 1));

	always_ff @(posedge ref_clk) begin
		if (!rst_n || state_q == ST_IDLE || tick) begin
			bit_tick_q <= 8'd0;
		end else begin
			bit_tick_q <= bit_tick_q + 8'd1;
		end
	end

	// R2 run-in: seven sine cycles, one per bit period of eight sub-ticks, locked to
	// the same divider that paces the data bits.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			phase_q <= 3'd0;
			runin_q <= 4'd0;
			sym_q <= 5'd0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (line_start && is_cap_line) state_q <= ST_WAIT;
				end
				ST_WAIT: begin
					if (!active_video) begin
						phase_q <= 3'd0;
					end else begin
						state_q <= ST_RUNIN;
						runin_q <= 4'(RUNIN_CYCLES);
					end
				end
				ST_RUNIN: begin
					if (tick) begin
						phase_q <= phase_q + 3'd1;
						if (phase_q == 3'(SINE_STEPS - 1)) begin
							runin_q <= runin_q - 4'd1; // see R2
							if (runin_q == 4'd1) begin
								state_q <= ST_DATA;
								sym_q <= 5'(BLANK_BITS + 1 + PAYLOAD_BITS);
							end
						end
					end
				end
				ST_DATA: begin
					if (tick) begin
						phase_q <= phase_q + 3'd1;
						if (from_fifo.ready) begin
							sym_q <= sym_q - 5'd1;
							if (sym_q == 5'd1) state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			video_out <= LEVEL_BLANK;
		end else if (cap_line_q) begin
			// R7 pixels are ignored for the whole caption line.
			if (state_q == ST_RUNIN) begin
				video_out <= sine_level(phase_q); // see R2
			end else if (state_q == ST_DATA) begin
				video_out <= from_fifo.data ? LEVEL_HIGH : LEVEL_BLANK;
			end else begin
				video_out <= LEVEL_BLANK; // see R7
			end
		end else begin
			video_out <= pixel_in;
		end
	end
endmodule : caption_inserter
`default_nettype wire

// File: caption_inserter_checker.sv
// Purpose: Port assertions for the caption inserter.
// Assumes: One clock, synchronous active-low reset.
// Notes: Tracks caption line and enable from the inputs.
`timescale 1ns/10ps
`default_nettype none
module caption_inserter_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic line_start,
	input wire logic [9:0] line_num,
	input wire logic field_even,
	input wire logic [9:0] pixel_in,
	input wire logic [9:0] video_out
);
	import caption_pkg::*;
	logic cap_q, en_q, wr_q;
	logic [11:0] a_q;
	wire logic rd = hsel && htrans[1] && !hwrite && hready;
	wire logic [7:0] ix = haddr[9:2];
	wire logic hit = haddr[31:10] == 22'h0 && haddr[1:0] == 2'b00 &&
		((ix >= IDX_EVEN_A && ix <= IDX_ODD_B) || ix == IDX_CTRL ||
		ix == IDX_STATUS);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			cap_q <= 1'b0;
		else if (line_start)
			cap_q <= (line_num == 10'(CAP_LINE_ODD) && !field_even) ||
				(line_num == 10'(CAP_LINE_EVEN) && field_even);
	end
	always_ff @(posedge ref_clk) begin
		wr_q <= rst_n && hsel && htrans[1] && hwrite && hready;
		a_q <= haddr[11:0];
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			en_q <= 1'b0;
		else if (wr_q && a_q == {2'b00, IDX_CTRL, 2'b00})
			en_q <= hwdata[CTRL_ENABLE_BIT];
	end
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	AST_READY: assert property (hreadyout)
		else $error("hreadyout low");
	AST_UNMAPPED: assert property (rd && !hit |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!rd |=> $stable(hrdata))
		else $error("hrdata changed without read");
	AST_CTRL_READ: assert property (rd && !wr_q &&
		haddr[11:0] == {2'b00, IDX_CTRL, 2'b00} |=> hrdata[0] == en_q)
		else $error("enable readback wrong");
	AST_PASS: assert property (!cap_q && !line_start
		|=> video_out == $past(pixel_in)) else $error("pixel not passed");
	AST_OFF_PASS: assert property (!en_q && !wr_q && !line_start
		|=> video_out == $past(pixel_in)) else $error("off line altered");
	AST_BIT_HOLD: assert property (cap_q && en_q &&
		video_out == LEVEL_HIGH && $past(video_out) == LEVEL_BLANK
		|-> (video_out == LEVEL_HIGH) [*8]) else $error("bit too short");
endmodule : caption_inserter_checker
`default_nettype wire

// File: caption_receiver_model.sv
// Purpose: Receiver that decodes caption bits from video_out.
// Assumes: 16 clocks per bit, levels from the package.
// Notes: Start bit is a high after at least two blank bits.
`timescale 1ns/10ps
`default_nettype none
module caption_receiver_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [9:0] video_out,
	output logic [15:0] rx_word,
	output var int rx_count
);
	import caption_pkg::*;
	int run_q, pos_q;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			run_q <= 0;
			pos_q <= 0;
			rx_count <= 0;
		end else if (pos_q == 0) begin
			run_q <= (video_out == LEVEL_BLANK) ? run_q + 1 : 0;
			if (video_out == LEVEL_HIGH && run_q >= 32)
				pos_q <= 1;
		end else begin
			pos_q <= (pos_q == 272) ? 0 : pos_q + 1;
			if (pos_q % 16 == 8 && pos_q > 16)
				rx_word[pos_q / 16 - 1] <= video_out > 10'h170;
			if (pos_q == 272) begin
				rx_count <= rx_count + 1;
				run_q <= 0;
			end
		end
	end
endmodule : caption_receiver_model
`default_nettype wire

// File: caption_inserter_test.sv
// Purpose: Self-checking bench for the caption inserter.
// Assumes: Single AHB-Lite master, receiver model on video_out.
// Notes: Lines are shortened to about 700 clocks.
`timescale 1ns/10ps
`default_nettype none
module caption_inserter_test;
	import caption_pkg::*;
	logic ref_clk, rst_n, hwrite, hsel, line_start, field_even, active_video;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [9:0] line_num, pixel_in, video_out, seen;
	logic hreadyout, hresp;
	wire logic hready = hreadyout;
	logic [15:0] rx_word;
	int rx_count, n_fail, num_checks, n0;
	localparam logic [9:0] PIX = 10'h155;
	caption_inserter u_dut (.*);
	caption_receiver_model u_rx (.*);
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// =====
	// Shared tasks.
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	function automatic logic [7:0] par(input logic [7:0] b);
		return {~^b[6:0], b[6:0]};
	endfunction : par
	task automatic bus(input logic wr, input logic [7:0] ix, input logic [31:0] d);
		haddr <= {22'h0, ix, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge ref_clk);
		while (!hready) @(posedge ref_clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge ref_clk);
		while (!hready) @(posedge ref_clk);
		q = hrdata;
	endtask : bus
	task automatic vline(input int n, input logic ev, input logic [7:0] d);
		n0 = rx_count;
		line_start <= 1'b1;
		line_num <= 10'(n);
		field_even <= ev;
		@(posedge ref_clk);
		line_start <= 1'b0;
		if (d != 8'h00) bus(1'b1, IDX_ODD_A, {24'h0, d});
		repeat (40) @(posedge ref_clk);
		active_video <= 1'b1;
		pixel_in <= PIX;
		repeat (300) @(posedge ref_clk);
		seen = video_out;
		repeat (300) @(posedge ref_clk);
		active_video <= 1'b0;
		pixel_in <= LEVEL_BLANK;
		repeat (40) @(posedge ref_clk);
	endtask : vline
	task automatic cap(input int n, input logic ev, input logic [15:0] w);
		vline(n, ev, 8'h00);
		chk("frames", n0 + 1, rx_count);
		chk("word", w, rx_word);
		chk("pixel ignored", 1, seen !== PIX);
	endtask : cap
	task automatic none(input int n, input logic ev);
		vline(n, ev, 8'h00);
		chk("frames", n0, rx_count);
		chk("pass", PIX, seen);
	endtask : none
	task automatic stop_test;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// =====
	// Scenarios.
	task automatic t_regs;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, IDX_EVEN_A + 8'(i), 32'h0);
			chk("byte reset", CAP_BYTE_RESET, q[7:0]);
			bus(1'b1, IDX_EVEN_A + 8'(i), 32'h5A00_0030 + i);
			bus(1'b0, IDX_EVEN_A + 8'(i), 32'h0);
			chk("byte rw", 8'h30 + 8'(i), q[7:0]);
		end
		bus(1'b0, IDX_CTRL, 32'h0);
		chk("ctrl reset", CTRL_RESET, q);
		bus(1'b1, 8'h98, 32'hFFFF_FFFF);
		bus(1'b0, 8'h98, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test regs done");
	endtask : t_regs
	task automatic t_lines;
		bus(1'b1, IDX_ODD_A, 32'h41);
		bus(1'b1, IDX_ODD_B, 32'h80);
		bus(1'b1, IDX_EVEN_A, 32'h7F);
		bus(1'b1, IDX_EVEN_B, 32'h03);
		bus(1'b1, IDX_CTRL, 32'h1);
		cap(21, 1'b0, {par(8'h80), par(8'h41)});
		bus(1'b0, IDX_STATUS, 32'h0);
		chk("status odd", 32'h1 << STAT_ODD_DONE_BIT, q);
		cap(284, 1'b1, {par(8'h03), par(8'h7F)});
		bus(1'b0, IDX_STATUS, 32'h0);
		chk("status even", 32'h1 << STAT_EVEN_DONE_BIT, q);
		none(20, 1'b0);
		none(21, 1'b1);
		none(284, 1'b0);
		$display("test lines done");
	endtask : t_lines
	task automatic t_shield;
		bus(1'b1, IDX_ODD_A, 32'h11);
		vline(21, 1'b0, 8'h22);
		chk("captured", {par(8'h80), par(8'h11)}, rx_word);
		cap(21, 1'b0, {par(8'h80), par(8'h22)});
		bus(1'b1, IDX_ODD_B, 32'h20);
		cap(21, 1'b0, {par(8'h20), par(8'h22)});
		bus(1'b1, IDX_ODD_A, 32'h0);
		bus(1'b1, IDX_ODD_B, 32'h0);
		cap(21, 1'b0, 16'h8080);
		bus(1'b1, IDX_CTRL, 32'h0);
		none(21, 1'b0);
		$display("test shield done");
	endtask : t_shield
	initial begin
		rst_n = 1'b0;
		{haddr, hwdata, htrans, hwrite, hsel} = '0;
		hsize = 3'b010;
		{line_start, line_num, field_even, active_video} = '0;
		pixel_in = LEVEL_BLANK;
		{n_fail, num_checks} = '0;
		repeat (4) @(posedge ref_clk);
		chk("reset video", LEVEL_BLANK, video_out);
		rst_n <= 1'b1;
		hsel <= 1'b1;
		@(posedge ref_clk);
		t_regs;
		t_lines;
		t_shield;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		stop_test;
	end
endmodule : caption_inserter_test
bind caption_inserter caption_inserter_checker u_chk (.*);
`default_nettype wire
